// File: page_decode.sv
// Memory map control: program page index, data steering and select decode
// Functional notes
// [R1] Page index maps one 16K block into window 0x8000 to 0xBFFF.
// [R2] Index value n selects paged block n, pages 0 to 63.
// [R3] Index writes allowed in all modes or special only; reads always.
// [R4] Reset value 0x00 for all-mode writes, 0x3C for special-only writes.
// [R5] Bus writes to the index take effect one cycle after the write.
// [R6] Call and return update the index over a dedicated path.
// [R7] Multiplex read buses to the CPU, steer write data, swap bytes.
// [R8] Every address decodes to registers, peripheral, or memory by mode; unclaimed space in non-expanded, non-emulation modes is external only if removed.
// [R9] Never more than one block select active at once.
// [R10] Overlapping blocks: only highest priority selected, lower hidden.
// [R11] Priority: debug, registers, RAM, EEPROM, flash, external.
// [R12] Expansion window has lowest priority among internal resources.
// [R13] Expanded modes: unclaimed space external; ports A, B go external.
// [R14] Port E enable set removes port E registers to external space.
// [R15] Special peripheral mode removes first 16 expansion registers.
// [R16] Emulation with port K enable removes port K registers.
// [R17] Port K bit 7 is active-low emulation select on flash access.
// [R18] With port K enable clear the select pin is general I/O.
// [R19] Exactly two external chip selects: emulation and external.
// [R20] Port K bit 6 external select: external space, no emulation select.
// [R21] Page window access internal or external by partition switches.
// [R22] Upper two index bits read zero, writes ignored.
`timescale 1ns/10ps
`include "page_decode_consts.svh"

module page_decode
#(
  parameter bit WRITE_ANY_MODE = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire page_decode_pkg::op_mode_type op_mode,
  input wire logic [1:0] paging_partition_switches,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_access,
  input wire logic [15:0] cpu_wdata,
  input wire logic cpu_byte_swap,
  input wire logic debug_active,
  input wire logic [15:0] ram_base,
  input wire logic [15:0] ram_mask,
  input wire logic [15:0] eeprom_base,
  input wire logic [15:0] eeprom_mask,
  input wire logic flash_enable,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] ram_rdata,
  input wire logic [15:0] eeprom_rdata,
  input wire logic [15:0] flash_rdata,
  input wire logic [15:0] ext_rdata,
  input wire logic [15:0] debug_rdata,
  input wire logic page_load,
  input wire logic [7:0] page_load_value,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic port_k7_gpio_out,
  input wire logic port_k6_gpio_out,
  output logic [7:0] reg_rdata_out,
  output logic [7:0] page_out,
  output page_decode_pkg::select_type selects,
  output logic [15:0] cpu_rdata,
  output logic [15:0] out_addr,
  output logic [15:0] out_wdata,
  output logic [5:0] ext_page,
  output logic emulation_chip_select_n,
  output logic external_chip_select_n,
  output logic port_k7_pin,
  output logic port_k6_pin
);

  // ****************************************************
  // Mode and map decode
  // ****************************************************
  logic special;
  logic expanded;
  logic emulation;
  logic port_e_external_enable;
  logic port_k_external_enable;
  logic in_regs;
  logic removed;
  logic in_window;
  logic window_internal;
  logic [5:0] threshold;
  logic ram_hit;
  logic eeprom_hit;
  logic flash_hit;
  page_decode_pkg::select_type sel;
  page_decode_pkg::state_type cur;
  page_decode_pkg::state_type next_state;

  always_comb
  begin
    special = op_mode inside {page_decode_pkg::mode_special_single,
                              page_decode_pkg::mode_special_expanded,
                              page_decode_pkg::mode_special_peripheral};
    expanded = op_mode inside {page_decode_pkg::mode_normal_expanded,
                               page_decode_pkg::mode_special_expanded,
                               page_decode_pkg::mode_emulation_expanded};
    emulation = op_mode inside {page_decode_pkg::mode_emulation_single,
                                page_decode_pkg::mode_emulation_expanded};
  end

  assign port_e_external_enable = cur.map_ctl[`MAPCTL_PORT_E];
  assign port_k_external_enable = cur.map_ctl[`MAPCTL_PORT_K];

  always_comb
  begin
    unique case (paging_partition_switches) // R21
      2'h0: threshold = `PAGE_INT_0;
      2'h1: threshold = `PAGE_INT_1;
      2'h2: threshold = `PAGE_INT_2;
      2'h3: threshold = `PAGE_INT_3;
    endcase
  end

  assign in_window = cpu_addr[15:14] == `WINDOW_TOP; // R1
  assign window_internal = cur.page >= threshold; // R2 R21
  assign in_regs = cpu_addr[15:10] == `REG_BASE;

  // Registers handed to the expansion bus stay readable externally only
  always_comb
  begin
    removed = 1'b0;
    if (expanded && cpu_addr[7:0] <= `PORT_AB_LAST && cpu_addr[9:8] == 2'h0)
      removed = 1'b1; // R13
    if (port_e_external_enable && cpu_addr[9:8] == 2'h0
        && (cpu_addr[7:0] == `PORT_E_DATA || cpu_addr[7:0] == `PORT_E_DIR))
      removed = 1'b1; // R14
    if (op_mode == page_decode_pkg::mode_special_peripheral && cpu_addr[9:8] == 2'h0
        && cpu_addr[7:0] <= `EXP_REGS_LAST)
      removed = 1'b1; // R15
    if (emulation && port_k_external_enable && cpu_addr[9:8] == 2'h0
        && (cpu_addr[7:0] == `PORT_K_DATA || cpu_addr[7:0] == `PORT_K_DIR))
      removed = 1'b1; // R16
  end

  assign ram_hit = (cpu_addr & ram_mask) == (ram_base & ram_mask);
  assign eeprom_hit = (cpu_addr & eeprom_mask) == (eeprom_base & eeprom_mask);
  assign flash_hit = flash_enable && cpu_addr[15] && (!in_window || window_internal);

  // Priority chain: an earlier hit masks every later one
  always_comb
  begin
    sel = '0;
    if (cpu_access)
    begin
      if (debug_active)
        sel.debug_sel = 1'b1; // R11
      else if (in_regs && !removed)
        sel.reg_sel = 1'b1; // R8 R10
      // Removed port registers go out before RAM or EEPROM can claim them
      else if (in_regs)
        sel.ext_sel = 1'b1; // R13 R14 R16
      else if (ram_hit)
        sel.ram_sel = 1'b1;
      else if (eeprom_hit)
        sel.eeprom_sel = 1'b1;
      else if (flash_hit)
        sel.flash_sel = 1'b1; // R12
      else if (expanded || emulation || removed)
        sel.ext_sel = 1'b1; // R13
    end
  end

  assign selects = sel; // R9

  // ****************************************************
  // Data steering
  // ****************************************************
  logic [15:0] mux_rd;

  always_comb
  begin
    mux_rd = 16'h0000;
    if (sel.debug_sel)
      mux_rd = debug_rdata;
    else if (sel.reg_sel)
      mux_rd = reg_rdata;
    else if (sel.ram_sel)
      mux_rd = ram_rdata;
    else if (sel.eeprom_sel)
      mux_rd = eeprom_rdata;
    else if (sel.flash_sel)
      mux_rd = flash_rdata;
    else if (sel.ext_sel)
      mux_rd = ext_rdata;
  end

  assign cpu_rdata = cpu_byte_swap ? {mux_rd[7:0], mux_rd[15:8]} : mux_rd; // R7
  assign out_addr = cpu_addr; // R7
  assign out_wdata = cpu_wdata;
  assign ext_page = cur.page;

  // ****************************************************
  // State update
  // ****************************************************
  logic emu_active;
  logic ext_active;

  // Emulation select follows flash space only in emulation mode
  assign emu_active = emulation && port_k_external_enable
                      && cpu_access && cpu_addr[15] && flash_enable; // R17
  // Unmapped or missing register locations never raise the external select
  assign ext_active = port_k_external_enable && sel.ext_sel
                      && !emu_active && !in_regs; // R20

  always_comb
  begin
    next_state = cur;
    next_state.emu_cs_n = !emu_active;
    next_state.ext_cs_n = !ext_active;
    if (reg_write && reg_addr == `PPI_OFFSET && (WRITE_ANY_MODE || special))
      next_state.page = reg_wdata[`PAGE_MSB:0]; // R3 R5 R22
    if (page_load)
      next_state.page = page_load_value[`PAGE_MSB:0]; // R6
    if (reg_write && reg_addr == `MAPCTL_OFFSET)
      next_state.map_ctl = {6'h00, reg_wdata[1:0]};
    next_state.rd_data = 8'h00;
    if (reg_read)
    begin
      unique case (reg_addr)
        `PPI_OFFSET: next_state.rd_data = {2'b00, cur.page}; // R22
        `MAPCTL_OFFSET: next_state.rd_data = cur.map_ctl;
        `STATUS_OFFSET: next_state.rd_data = {6'h00, ~cur.emu_cs_n, ~cur.ext_cs_n};
        default: next_state.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur.page <= WRITE_ANY_MODE ? 6'(`PPI_RESET_ALL) : 6'(`PPI_RESET_SPECIAL); // R4
      cur.map_ctl <= 8'h00;
      cur.rd_data <= 8'h00;
      cur.emu_cs_n <= 1'b1;
      cur.ext_cs_n <= 1'b1;
    end
    else
      cur <= next_state;
  end

  assign reg_rdata_out = cur.rd_data;
  assign page_out = {2'b00, cur.page};
  assign emulation_chip_select_n = cur.emu_cs_n; // R19
  assign external_chip_select_n = cur.ext_cs_n;
  assign port_k7_pin = port_k_external_enable ? cur.emu_cs_n : port_k7_gpio_out; // R18
  assign port_k6_pin = port_k_external_enable ? cur.ext_cs_n : port_k6_gpio_out;

  // ****************************************************
  // Checks
  // ****************************************************
  property p_one_select;
    @(posedge clk) disable iff (rst) $onehot0(selects);
  endproperty
  a_one_select: assert property (p_one_select) else $error("two selects"); // R9

  property p_write_one_cycle;
    @(posedge clk) disable iff (rst)
      (reg_write && reg_addr == `PPI_OFFSET && WRITE_ANY_MODE && !page_load)
      |=> page_out == {2'b00, $past(reg_wdata[5:0])};
  endproperty
  a_write_one_cycle: assert property (p_write_one_cycle) else $error("page write lost"); // R5

  property p_load;
    @(posedge clk) disable iff (rst) page_load |=> page_out[5:0] == $past(page_load_value[5:0]);
  endproperty
  a_load: assert property (p_load) else $error("page load lost"); // R6

  property p_upper_zero;
    @(posedge clk) disable iff (rst) page_out[7:6] == 2'b00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set"); // R22

  property p_reg_over_ram;
    @(posedge clk) disable iff (rst)
      (cpu_access && !debug_active && in_regs && !removed) |-> !selects.ram_sel;
  endproperty
  a_reg_over_ram: assert property (p_reg_over_ram) else $error("ram over regs"); // R10

  property p_cs_exclusive;
    @(posedge clk) disable iff (rst) !(!emulation_chip_select_n && !external_chip_select_n);
  endproperty
  a_cs_exclusive: assert property (p_cs_exclusive) else $error("both chip selects"); // R20

  property p_emu_cs;
    @(posedge clk) disable iff (rst) emu_active |=> !emulation_chip_select_n;
  endproperty
  a_emu_cs: assert property (p_emu_cs) else $error("emu select late"); // R17

  property p_gpio;
    @(posedge clk) disable iff (rst) !port_k_external_enable |-> port_k7_pin == port_k7_gpio_out;
  endproperty
  a_gpio: assert property (p_gpio) else $error("pin not gpio"); // R18

  property p_window_ext;
    @(posedge clk) disable iff (rst)
      (cpu_access && expanded && !debug_active && in_window && !window_internal
       && !ram_hit && !eeprom_hit) |-> selects.ext_sel;
  endproperty
  a_window_ext: assert property (p_window_ext) else $error("window not external"); // R21

  property p_window_internal;
    @(posedge clk) disable iff (rst)
      (cpu_access && flash_enable && !debug_active && in_window && window_internal
       && !ram_hit && !eeprom_hit) |-> selects.flash_sel;
  endproperty
  a_window_internal: assert property (p_window_internal) else $error("window not internal"); // R1 R21

  property p_no_access;
    @(posedge clk) disable iff (rst) !cpu_access |-> selects == '0;
  endproperty
  a_no_access: assert property (p_no_access) else $error("select without access"); // R8

  property p_debug_first;
    @(posedge clk) disable iff (rst) (cpu_access && debug_active) |-> selects.debug_sel;
  endproperty
  a_debug_first: assert property (p_debug_first) else $error("debug space not first"); // R11

  property p_ram_over_eeprom;
    @(posedge clk) disable iff (rst)
      (cpu_access && !debug_active && !in_regs && ram_hit) |-> selects.ram_sel;
  endproperty
  a_ram_over_eeprom: assert property (p_ram_over_eeprom) else $error("ram hidden"); // R10

  // Vectors live in the upper block, so it must never fall to a window
  property p_flash_upper;
    @(posedge clk) disable iff (rst)
      (cpu_access && flash_enable && !debug_active && cpu_addr[15:14] == 2'h3
       && !ram_hit && !eeprom_hit) |-> selects.flash_sel;
  endproperty
  a_flash_upper: assert property (p_flash_upper) else $error("upper block lost"); // R12

  property p_port_ab_out;
    @(posedge clk) disable iff (rst)
      (cpu_access && !debug_active && expanded && cpu_addr[15:2] == 14'h0000)
      |-> selects.ext_sel;
  endproperty
  a_port_ab_out: assert property (p_port_ab_out) else $error("port a b not external"); // R13

  property p_port_e_out;
    @(posedge clk) disable iff (rst)
      (cpu_access && !debug_active && port_e_external_enable && cpu_addr[15:8] == 8'h00
       && (cpu_addr[7:0] == `PORT_E_DATA || cpu_addr[7:0] == `PORT_E_DIR)) |-> selects.ext_sel;
  endproperty
  a_port_e_out: assert property (p_port_e_out) else $error("port e not external"); // R14

  property p_periph_out;
    @(posedge clk) disable iff (rst)
      (cpu_access && op_mode == page_decode_pkg::mode_special_peripheral
       && cpu_addr[15:4] == 12'h000) |-> !selects.reg_sel;
  endproperty
  a_periph_out: assert property (p_periph_out) else $error("expansion register mapped"); // R15

  property p_port_k_out;
    @(posedge clk) disable iff (rst)
      (cpu_access && !debug_active && emulation && port_k_external_enable
       && cpu_addr[15:8] == 8'h00
       && (cpu_addr[7:0] == `PORT_K_DATA || cpu_addr[7:0] == `PORT_K_DIR)) |-> selects.ext_sel;
  endproperty
  a_port_k_out: assert property (p_port_k_out) else $error("port k not external"); // R16

  property p_ext_cs_regs;
    @(posedge clk) disable iff (rst) in_regs |=> external_chip_select_n;
  endproperty
  a_ext_cs_regs: assert property (p_ext_cs_regs) else $error("external select on register"); // R20

  property p_k6_gpio;
    @(posedge clk) disable iff (rst) !port_k_external_enable |-> port_k6_pin == port_k6_gpio_out;
  endproperty
  a_k6_gpio: assert property (p_k6_gpio) else $error("pin 6 not gpio"); // R18

  property p_pass_through;
    @(posedge clk) disable iff (rst) out_addr == cpu_addr && out_wdata == cpu_wdata;
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("address or data not steered"); // R7

  property p_swap;
    @(posedge clk) disable iff (rst)
      (cpu_byte_swap && selects.flash_sel) |-> cpu_rdata == {flash_rdata[7:0], flash_rdata[15:8]};
  endproperty
  a_swap: assert property (p_swap) else $error("bytes not swapped"); // R7

  property p_read_page;
    @(posedge clk) disable iff (rst)
      (reg_read && reg_addr == `PPI_OFFSET) |=> reg_rdata_out == $past(page_out);
  endproperty
  a_read_page: assert property (p_read_page) else $error("page read wrong"); // R3 R22

endmodule

// File: page_decode_consts.svh
// Constants for the memory map and page decode block
`ifndef PAGE_DECODE_CONSTS_SVH
`define PAGE_DECODE_CONSTS_SVH

// Register offsets on the plain register port
`define PPI_OFFSET 8'h30
`define MAPCTL_OFFSET 8'h31
`define STATUS_OFFSET 8'h32

// Page index field
`define PAGE_MSB 5
`define PAGE_WIDTH 6
`define PPI_RESET_ALL 8'h00
`define PPI_RESET_SPECIAL 8'h3C

// Page window bounds, bits 15:14 of the address
`define WINDOW_TOP 2'h2

// Internal register block: bits 15:10 of the address
`define REG_BASE 6'h00
// First 16 bus-expansion registers are at 0x0000..0x000F
`define EXP_REGS_LAST 8'h0F
// Port A/B data and direction at 0x00..0x03, port E at 0x08/0x09
`define PORT_AB_LAST 8'h03
`define PORT_E_DATA 8'h08
`define PORT_E_DIR 8'h09
// Port K data and direction at 0x32/0x33
`define PORT_K_DATA 8'h32
`define PORT_K_DIR 8'h33

// Internal page thresholds per partition switch setting
`define PAGE_INT_0 6'h38
`define PAGE_INT_1 6'h30
`define PAGE_INT_2 6'h20
`define PAGE_INT_3 6'h00

// Mapping control bit positions
`define MAPCTL_PORT_E 0
`define MAPCTL_PORT_K 1

`endif

// File: page_decode_pkg.sv
// Types for the memory map and page decode block
package page_decode_pkg;

  typedef enum logic [2:0]
  {
    mode_normal_single,
    mode_normal_expanded,
    mode_special_single,
    mode_special_expanded,
    mode_special_peripheral,
    mode_emulation_single,
    mode_emulation_expanded
  } op_mode_type;

  typedef struct packed
  {
    logic debug_sel;
    logic reg_sel;
    logic ram_sel;
    logic eeprom_sel;
    logic flash_sel;
    logic ext_sel;
  } select_type;

  typedef struct packed
  {
    logic [5:0] page;
    logic [7:0] map_ctl;
    logic [7:0] rd_data;
    logic emu_cs_n;
    logic ext_cs_n;
  } state_type;

endpackage

// File: memory_sources.sv
// Model of the register, memory and external sources behind the decoder
`timescale 1ns/10ps

module memory_sources
(
  output logic [15:0] reg_rd,
  output logic [15:0] ram_rd,
  output logic [15:0] eep_rd,
  output logic [15:0] fl_rd,
  output logic [15:0] ext_rd,
  output logic [15:0] dbg_rd
);
  // Distinct byte patterns per source, so a wrong mux leg or a missed swap shows
  assign dbg_rd = 16'hD0D1;
  assign reg_rd = 16'h1A2B;
  assign ram_rd = 16'h3C4D;
  assign eep_rd = 16'h5E6F;
  assign fl_rd = 16'h7081;
  assign ext_rd = 16'h92A3;
endmodule

// File: tb_page_decode.sv
// Self-checking testbench for the memory map and page decode block
`timescale 1ns/10ps

module tb_page_decode;
  typedef struct packed
  {
    logic [2:0] m;
    logic [1:0] s;
    logic [7:0] mc;
    logic [7:0] pg;
    logic d;
    logic [15:0] a;
    logic [5:0] e;
  } row_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  page_decode_pkg::op_mode_type op_mode = page_decode_pkg::mode_normal_single;
  logic [1:0] sw = 2'h0;
  logic [15:0] addr = 16'h0000;
  logic acc = 1'b1;
  logic swap = 1'b0;
  logic dbg = 1'b0;
  logic fl_en = 1'b1;
  logic load = 1'b0;
  logic [7:0] load_val = 8'h00;
  logic [7:0] raddr = 8'h00;
  logic [7:0] rwdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic gk7 = 1'b0;
  logic gk6 = 1'b1;
  logic [15:0] reg_rd, ram_rd, eep_rd, fl_rd, ext_rd, dbg_rd, cpu_rdata, out_addr, out_wdata;
  logic [7:0] rdata, page_out;
  page_decode_pkg::select_type sel;
  logic [5:0] ext_page;
  logic cs_emu_n, cs_ext_n, k7, k6, emu, ext;
  int bad_count = 0;
  int checks_done = 0;
  row_type rows [24] = '{
    '{3'h0, 2'h0, 8'h00, 8'h00, 1'b1, 16'h0100, 6'h20}, '{3'h0, 2'h0, 8'h00, 8'h00, 1'b0, 16'h0100, 6'h10},
    '{3'h0, 2'h0, 8'h00, 8'h00, 1'b0, 16'h0800, 6'h04}, '{3'h0, 2'h0, 8'h00, 8'h00, 1'b0, 16'h1800, 6'h08},
    '{3'h0, 2'h0, 8'h00, 8'h00, 1'b0, 16'h2100, 6'h00}, '{3'h0, 2'h0, 8'h00, 8'h00, 1'b0, 16'hC000, 6'h02},
    '{3'h0, 2'h0, 8'h00, 8'h00, 1'b0, 16'h0001, 6'h10}, '{3'h1, 2'h0, 8'h00, 8'h00, 1'b0, 16'h0001, 6'h01},
    '{3'h1, 2'h0, 8'h00, 8'h00, 1'b0, 16'h4000, 6'h01}, '{3'h1, 2'h0, 8'h01, 8'h00, 1'b0, 16'h0008, 6'h01},
    '{3'h1, 2'h0, 8'h00, 8'h00, 1'b0, 16'h0008, 6'h10}, '{3'h6, 2'h0, 8'h02, 8'h00, 1'b0, 16'h0032, 6'h01},
    '{3'h6, 2'h0, 8'h02, 8'h00, 1'b0, 16'hC000, 6'h02}, '{3'h6, 2'h0, 8'h02, 8'h00, 1'b0, 16'h4000, 6'h01},
    '{3'h6, 2'h0, 8'h00, 8'h00, 1'b0, 16'hC000, 6'h02}, '{3'h1, 2'h0, 8'h02, 8'h00, 1'b0, 16'h0001, 6'h01},
    '{3'h1, 2'h0, 8'h00, 8'h37, 1'b0, 16'hBFFF, 6'h01}, '{3'h1, 2'h0, 8'h00, 8'h38, 1'b0, 16'h8000, 6'h02},
    '{3'h1, 2'h1, 8'h00, 8'h2F, 1'b0, 16'h8000, 6'h01}, '{3'h1, 2'h1, 8'h00, 8'h30, 1'b0, 16'h8000, 6'h02},
    '{3'h1, 2'h2, 8'h00, 8'h1F, 1'b0, 16'h8000, 6'h01}, '{3'h1, 2'h2, 8'h00, 8'h20, 1'b0, 16'h8000, 6'h02},
    '{3'h1, 2'h3, 8'h00, 8'h00, 1'b0, 16'h8000, 6'h02}, '{3'h1, 2'h0, 8'h00, 8'h38, 1'b0, 16'h7FFF, 6'h01}};

  always #12.5 clk = ~clk;

  memory_sources memory_sources_inst (.reg_rd(reg_rd), .ram_rd(ram_rd), .eep_rd(eep_rd),
    .fl_rd(fl_rd), .ext_rd(ext_rd), .dbg_rd(dbg_rd));

  // Fixed map: RAM 0x1000-0x1FFF sits on top of EEPROM 0x0000-0x1FFF
  page_decode page_decode_inst (.clk(clk), .rst(rst), .op_mode(op_mode),
    .paging_partition_switches(sw), .cpu_addr(addr), .cpu_access(acc), .cpu_wdata(~addr),
    .cpu_byte_swap(swap), .debug_active(dbg), .ram_base(16'h1000), .ram_mask(16'hF000),
    .eeprom_base(16'h0000), .eeprom_mask(16'hE000), .flash_enable(fl_en), .reg_rdata(reg_rd),
    .ram_rdata(ram_rd), .eeprom_rdata(eep_rd), .flash_rdata(fl_rd), .ext_rdata(ext_rd),
    .debug_rdata(dbg_rd), .page_load(load), .page_load_value(load_val), .reg_addr(raddr),
    .reg_wdata(rwdata), .reg_write(wr_en), .reg_read(rd_en), .port_k7_gpio_out(gk7),
    .port_k6_gpio_out(gk6), .reg_rdata_out(rdata), .page_out(page_out), .selects(sel),
    .cpu_rdata(cpu_rdata), .out_addr(out_addr), .out_wdata(out_wdata), .ext_page(ext_page),
    .emulation_chip_select_n(cs_emu_n), .external_chip_select_n(cs_ext_n), .port_k7_pin(k7),
    .port_k6_pin(k6));

  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    raddr <= a;
    rwdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    raddr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(16'(rdata), 16'(exp));
  endtask

  task automatic apply(input logic [2:0] m, input logic [15:0] a);
    @(posedge clk);
    op_mode <= page_decode_pkg::op_mode_type'(m);
    addr <= a;
    @(posedge clk);
    #1;
  endtask

  function automatic logic [15:0] src(input logic [5:0] s, input logic b);
    logic [15:0] v;
    v = s[5] ? 16'hD0D1 : s[4] ? 16'h1A2B : s[3] ? 16'h3C4D : s[2] ? 16'h5E6F : s[1] ? 16'h7081 : 16'h92A3;
    return b ? {v[7:0], v[15:8]} : v;
  endfunction

  task automatic final_report;
    $display("Checks done %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ************************************************
  // Main sequence
  // ************************************************
  initial
  begin
    repeat (20) @(posedge clk);
    chk(16'({cs_emu_n, cs_ext_n}), 16'h0003);
    rst <= 1'b0;
    rd(8'h30, 8'h00);
    chk(16'(page_out), 16'h0000);
    $display("Reset test done");
    for (int i = 0; i < 24; i++)
    begin
      wr(8'h31, rows[i].mc);
      wr(8'h30, rows[i].pg);
      sw <= rows[i].s;
      dbg <= rows[i].d;
      swap <= i[0];
      gk7 <= i[1];
      gk6 <= ~i[1];
      apply(rows[i].m, rows[i].a);
      emu = (rows[i].m == 3'h5 || rows[i].m == 3'h6) && rows[i].mc[1] && rows[i].a[15];
      ext = rows[i].mc[1] && rows[i].e[0] && !emu && rows[i].a >= 16'h0400;
      chk(16'(sel), 16'(rows[i].e));
      if (rows[i].e != 6'h00)
        chk(cpu_rdata, src(rows[i].e, i[0]));
      chk(out_addr, rows[i].a);
      chk(out_wdata, ~rows[i].a);
      chk(16'(ext_page), 16'(rows[i].pg[5:0]));
      chk(16'({cs_emu_n, cs_ext_n}), 16'({!emu, !ext}));
      chk(16'(k7), 16'(rows[i].mc[1] ? !emu : i[1]));
      chk(16'(k6), 16'(rows[i].mc[1] ? !ext : !i[1]));
      dbg <= 1'b0;
    end
    $display("Decode table done");
    wr(8'h31, 8'h00);
    wr(8'h30, 8'h05);
    #1;
    chk(16'(page_out), 16'h0005);
    rd(8'h30, 8'h05);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h3F);
    rd(8'h40, 8'h00);
    // Dedicated load must win over a bus write in the same cycle
    @(posedge clk);
    load <= 1'b1;
    load_val <= 8'h07;
    raddr <= 8'h30;
    rwdata <= 8'h11;
    wr_en <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    wr_en <= 1'b0;
    #1;
    chk(16'(page_out), 16'h0007);
    $display("Page register test done");
    wr(8'h31, 8'h02);
    apply(3'h5, 16'hC000);
    rd(8'h32, 8'h02);
    chk(16'(k7), 16'h0000);
    apply(3'h4, 16'h000C);
    chk(16'(sel.reg_sel), 16'h0000);
    apply(3'h4, 16'h0010);
    chk(16'(sel), 16'h0010);
    fl_en <= 1'b0;
    apply(3'h0, 16'hC000);
    chk(16'(sel), 16'h0000);
    acc <= 1'b0;
    apply(3'h0, 16'h0100);
    chk(16'(sel), 16'h0000);
    $display("Mode test done");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(16'(page_out), 16'h0000);
    chk(16'({cs_emu_n, cs_ext_n}), 16'h0003);
    rd(8'h31, 8'h00);
    $display("Mid-run reset test done");
    final_report();
  end
endmodule
